// File: verilog/shp_consts.svh
// Constants for the host port: decode, straps, timing.
// Included by the host port package and design files.
`ifndef SHP_CONSTS_SVH
`define SHP_CONSTS_SVH
`define SHP_ADDR_W          7
`define SHP_REG_CNT         8
`define SHP_FIFO_DEPTH      8
`define SHP_HOLDOFF_RESET   8'h10
`define SHP_SYNC_DEPTH      2
`endif

// File: verilog/shp_pkg.sv
// Types shared by the host port design.
// Assumes shp_consts.svh is on the include path.
`include "shp_consts.svh"
package shp_pkg;
   typedef struct packed
   {
      logic       sel_low;
      logic       rd_low;
      logic       wr_low;
      logic       queue_sel;
      logic [6:0] addr;
   } shp_host_ctl_t;
   typedef struct packed
   {
      logic [7:0] holdoff;
      logic       polarity_high;
      logic       open_drain;
      logic [7:0] source_mask;
   } shp_irq_cfg_t;
   typedef enum logic [1:0] {SHP_IDLE, SHP_WAIT_HI, SHP_DONE} shp_state_t;
endpackage

// File: verilog/shp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and active high async reset.
module shp_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
)
(
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;
   initial
   begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("shp_fifo depth must be a power of two");
   end
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];
   always_ff @(posedge clock)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule

// File: verilog/shp_host_port.sv
// SRAM-like asynchronous host port with one interrupt output.
// Assumes host strobes asynchronous to clock; a core drains/fills queues.
`include "shp_consts.svh"
module shp_host_port
#(
   parameter int QDEPTH = `SHP_FIFO_DEPTH
)
(
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   input  wire logic                  port_select_low,
   input  wire logic                  read_strobe_low,
   input  wire logic                  write_strobe_low,
   input  wire logic                  queue_select,
   input  wire logic [7:1]            host_addr,
   input  wire logic [31:0]           data_in,
   output logic      [31:0]           data_out,
   output logic                       data_oe_low,
   output logic                       upper_pulldown_en,
   input  wire logic                  bus_width_strap,
   input  wire logic                  big_endian,
   input  wire shp_pkg::shp_irq_cfg_t irq_cfg,
   input  wire logic [7:0]            irq_sources,
   output logic                       irq_out,
   output logic                       irq_oe_low,
   input  wire logic                  low_power,
   output logic                       wake,
   output logic                       tx_valid,
   input  wire logic                  tx_ready,
   output logic      [31:0]           tx_data,
   input  wire logic                  rx_valid,
   output logic                       rx_ready,
   input  wire logic [31:0]           rx_data,
   output logic                       reg_wr,
   output logic      [5:0]            reg_index,
   output logic      [31:0]           reg_wdata,
   input  wire logic [31:0]           reg_rdata
);
   import shp_pkg::*;

   initial
   begin
      if (QDEPTH < 2)
         $error("shp_host_port queue depth too small");
   end

   // ==========================================================
   // Pin synchronisers
   localparam int NSYNC = 4 + `SHP_ADDR_W + 32 + 1;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= {~port_select_low, ~read_strobe_low, ~write_strobe_low,
                   queue_select, host_addr, data_in, bus_width_strap};
         sync2 <= sync1;
      end
   end
   logic        sel;
   logic        rd;
   logic        wr;
   logic        qsel;
   logic [6:0]  addr;
   logic [31:0] din;
   logic        strap_s;
   assign {sel, rd, wr, qsel, addr, din, strap_s} = sync2;

   // ==========================================================
   // Width strap capture
   logic       wide;
   logic       strap_taken;
   logic [1:0] strap_age;
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wide        <= 1'b0;
         strap_taken <= 1'b0;
         strap_age   <= 2'h0;
      end
      else if (!strap_taken)
      begin
         // Synchroniser holds its reset value until the pin has passed it
         if (strap_age == 2'(`SHP_SYNC_DEPTH))
         begin
            wide        <= strap_s;
            strap_taken <= 1'b1;
         end
         else
            strap_age <= strap_age + 2'h1;
      end
   end
   assign upper_pulldown_en = !wide;

   // ==========================================================
   // Access detection
   logic rd_act;
   logic wr_act;
   logic rd_prev;
   logic wr_prev;
   logic rd_start;
   logic rd_fetch;
   logic wr_done;
   assign rd_act   = sel && rd;
   assign wr_act   = sel && wr;
   assign rd_start = rd_act && !rd_prev;
   assign wr_done  = !wr_act && wr_prev;
   logic [6:0]  wr_addr;
   logic        wr_q;
   logic [31:0] wr_bus;
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_prev <= 1'b0;
         rd_fetch <= 1'b0;
         wr_prev <= 1'b0;
         wr_addr <= '0;
         wr_q    <= 1'b0;
         wr_bus  <= '0;
      end
      else
      begin
         rd_prev <= rd_act;
         rd_fetch <= rd_start;
         wr_prev <= wr_act;
         if (wr_act)
         begin
            wr_addr <= addr;
            wr_q    <= qsel;
            wr_bus  <= din;
         end
      end
   end

   // Queue selected by queue_select, or by upper address bits a[6:4] all zero
   function automatic logic is_queue(input logic q, input logic [6:0] a);
      is_queue = q || (a[6:4] == 3'b000);
   endfunction
   function automatic logic [31:0] swap(input logic [31:0] d, input logic be);
      swap = be ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
   endfunction

   // ==========================================================
   // Wake and first-read gate
   logic read_seen;
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         read_seen <= 1'b0;
      else if (low_power)
         read_seen <= 1'b0;
      else if (rd_start)
         read_seen <= 1'b1;
   end
   assign wake = low_power && wr_act;

   // ==========================================================
   // Half-word assembly and write dispatch
   logic [15:0] low_half;
   logic        tx_push;
   logic [31:0] tx_word;
   logic        tx_in_ready;
   logic        wr_ok;
   logic [31:0] full_w;
   assign wr_ok  = wr_done && read_seen && !low_power;
   assign full_w = wide ? swap(wr_bus, big_endian)
                        : swap({wr_bus[15:0], low_half}, big_endian);
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         low_half <= '0;
      else if (wr_ok && !wide && !wr_addr[0])
         low_half <= wr_bus[15:0];
   end
   logic complete;
   assign complete = wide || wr_addr[0];
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_push   <= 1'b0;
         tx_word   <= '0;
         reg_wr    <= 1'b0;
         reg_index <= '0;
         reg_wdata <= '0;
      end
      else
      begin
         tx_push <= 1'b0;
         reg_wr  <= 1'b0;
         if (wr_ok && complete)
         begin
            if (is_queue(wr_q, wr_addr))
            begin
               tx_push <= tx_in_ready;
               tx_word <= full_w;
            end
            else
            begin
               reg_wr    <= 1'b1;
               reg_index <= wr_addr[6:1];
               reg_wdata <= full_w;
            end
         end
         // Point the register file at the read target one cycle before fetch
         else if (rd_start && !is_queue(qsel, addr))
            reg_index <= addr[6:1];
      end
   end
   shp_fifo #(.WIDTH(32), .DEPTH(QDEPTH)) u_tx_fifo
   (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .in_valid  (tx_push),
      .in_ready  (tx_in_ready),
      .in_data   (tx_word),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (tx_data)
   );

   // ==========================================================
   // Read path
   logic        rxq_valid;
   logic        rxq_pop;
   logic [31:0] rxq_data;
   logic [31:0] rd_word;
   shp_fifo #(.WIDTH(32), .DEPTH(QDEPTH)) u_rx_fifo
   (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .in_data   (rx_data),
      .out_valid (rxq_valid),
      .out_ready (rxq_pop),
      .out_data  (rxq_data)
   );
   assign rd_word = is_queue(qsel, addr) ? swap(rxq_data, big_endian)
                                         : swap(reg_rdata, big_endian);
   // Pop on the last half of a queue word
   assign rxq_pop = rd_fetch && rxq_valid && is_queue(qsel, addr)
                    && (wide || addr[0]);
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         data_out <= '0;
      else if (rd_fetch)
      begin
         if (wide)
            data_out <= rd_word;
         else
            data_out <= {16'h0000, addr[0] ? rd_word[31:16] : rd_word[15:0]};
      end
   end
   assign data_oe_low = !rd_act;

   // ==========================================================
   // Interrupt with deassert hold-off
   logic       irq_req;
   logic       irq_on;
   logic [7:0] hold_cnt;
   assign irq_req = |(irq_sources & irq_cfg.source_mask);
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         irq_on   <= 1'b0;
         hold_cnt <= '0;
      end
      else if (irq_on)
      begin
         if (!irq_req)
         begin
            irq_on   <= 1'b0;
            hold_cnt <= irq_cfg.holdoff;
         end
      end
      else if (hold_cnt != 8'h00)
         hold_cnt <= hold_cnt - 8'h01;
      else if (irq_req)
         irq_on <= 1'b1;
   end
   // Open drain: drive low only when active, else release
   always_comb
   begin
      if (irq_cfg.open_drain)
      begin
         irq_out    = 1'b0;
         irq_oe_low = !irq_on;
      end
      else
      begin
         irq_out    = irq_cfg.polarity_high ? irq_on : !irq_on;
         irq_oe_low = 1'b0;
      end
   end

   // ==========================================================
   // Checks
   AST_HOLDOFF: assert property (@(posedge clock) disable iff (sys_rst)
      $fell(irq_on) && irq_cfg.holdoff != 8'h00 |=> !irq_on)
      else $error("interrupt reasserted inside hold-off");
   AST_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
      low_power && sel && wr |-> wake)
      else $error("write did not wake device");
   AST_PULLDOWN: assert property (@(posedge clock) disable iff (sys_rst)
      strap_taken |-> upper_pulldown_en == !wide)
      else $error("pull-down state wrong");
   AST_NOWRITE: assert property (@(posedge clock) disable iff (sys_rst)
      !read_seen |=> !reg_wr && !tx_push)
      else $error("write took effect before first read");
   AST_STRAP: assert property (@(posedge clock) disable iff (sys_rst)
      strap_taken |=> $stable(wide))
      else $error("width changed after capture");
   AST_RDOE: assert property (@(posedge clock) disable iff (sys_rst)
      !sel |-> data_oe_low)
      else $error("data driven without select");
   AST_OD: assert property (@(posedge clock) disable iff (sys_rst)
      irq_cfg.open_drain && !irq_on |-> irq_oe_low)
      else $error("open drain drives while idle");
   AST_IRQ: assert property (@(posedge clock) disable iff (sys_rst)
      !irq_on && hold_cnt == 8'h00 && irq_req |=> irq_on)
      else $error("interrupt not raised");
endmodule

// File: testbench/shp_core_model.sv
// Core-side model of the host port: register file, tx sink, rx source.
// Assumes the port's single clock and active high async reset.
module shp_core_model
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        tx_stall,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [31:0] tx_data,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic      [31:0] rx_data,
   input  wire logic        reg_wr,
   input  wire logic [5:0]  reg_index,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] regs [64];
   logic [31:0] tx_log [16];
   logic [4:0]  tx_count;
   logic [15:0] rx_count;
   // ==========================================
   // Word-wide paths behind the port
   assign tx_ready  = !tx_stall;
   assign rx_valid  = 1'b1;
   assign rx_data   = {16'hC0DE, rx_count};
   assign reg_rdata = regs[reg_index];
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_count <= 5'h00;
      end
      else if (tx_valid && tx_ready)
      begin
         tx_log[tx_count[3:0]] <= tx_data;
         tx_count <= tx_count + 5'h01;
      end
   end
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         rx_count <= 16'h0000;
      else if (rx_ready)
         rx_count <= rx_count + 16'h0001;
   end
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < 64; i++)
            regs[i] <= 32'h00000000;
      end
      else if (reg_wr)
      begin
         regs[reg_index] <= reg_wdata;
      end
   end
endmodule

// File: testbench/sram_like_host_port_tb_top.sv
// Self-checking bench for the host port, host side driven by tasks.
// Assumes shp_core_model stands on the core side of the port.
module sram_like_host_port_tb_top;
   import shp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, sys_rst = 1'b1, port_select_low = 1'b1;
   logic read_strobe_low = 1'b1, write_strobe_low = 1'b1, queue_select = 1'b0;
   logic [7:1] host_addr = 7'h00;
   logic [31:0] data_in = 32'h00000000, data_out, tx_data, rx_data, reg_wdata, reg_rdata;
   logic data_oe_low, upper_pulldown_en, irq_out, irq_oe_low, wake, woke = 1'b0;
   logic bus_width_strap = 1'b1, big_endian = 1'b0, low_power = 1'b0, tx_stall = 1'b0;
   logic [7:0] irq_sources = 8'h00;
   shp_irq_cfg_t irq_cfg = '{8'h10, 1'b1, 1'b0, 8'h01};
   logic tx_valid, tx_ready, rx_valid, rx_ready, reg_wr;
   logic [5:0] reg_index;
   int failures = 0, n_tests = 0, cycles = 0;
   always #10 clock = !clock;
   shp_host_port i_shp_host_port (.clock(clock), .sys_rst(sys_rst),
      .port_select_low(port_select_low), .read_strobe_low(read_strobe_low),
      .write_strobe_low(write_strobe_low), .queue_select(queue_select),
      .host_addr(host_addr), .data_in(data_in), .data_out(data_out),
      .data_oe_low(data_oe_low), .upper_pulldown_en(upper_pulldown_en),
      .bus_width_strap(bus_width_strap), .big_endian(big_endian), .irq_cfg(irq_cfg),
      .irq_sources(irq_sources), .irq_out(irq_out), .irq_oe_low(irq_oe_low),
      .low_power(low_power), .wake(wake), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .reg_wr(reg_wr), .reg_index(reg_index), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata));
   shp_core_model i_shp_core_model (.clock(clock), .sys_rst(sys_rst), .tx_stall(tx_stall),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .reg_wr(reg_wr), .reg_index(reg_index),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   always @(posedge clock)
   begin
      if (wake === 1'b1)
         woke = 1'b1;
   end
   // ==========================================
   // Host access tasks
   task automatic tally_and_finish();
      if (failures == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Strobes held 6 cycles low then 6 high, above the 3-cycle minimum
   task automatic access(input logic wr, input logic sel, input logic qs,
                         input logic [6:0] a, input logic [31:0] d);
      @(posedge clock);
      port_select_low  <= !sel;
      queue_select     <= qs;
      host_addr        <= a;
      data_in          <= d;
      read_strobe_low  <= wr;
      write_strobe_low <= !wr;
      wait_cyc(6);
      chk({31'h0, data_oe_low}, {31'h0, !(sel && !wr)});
      read_strobe_low  <= 1'b1;
      write_strobe_low <= 1'b1;
      wait_cyc(6);
      port_select_low  <= 1'b1;
   endtask
   task automatic do_reset(input logic strap);
      @(posedge clock);
      sys_rst         <= 1'b1;
      bus_width_strap <= strap;
      wait_cyc(16);
      sys_rst <= 1'b0;
      wait_cyc(6);
   endtask
   task automatic irq_case(input logic pol, input logic od, input logic [7:0] src);
      logic act;
      act = |(src & 8'h01);
      @(posedge clock);
      irq_cfg     <= '{8'h10, pol, od, 8'h01};
      irq_sources <= src;
      wait_cyc(40);
      chk({30'h0, irq_oe_low, irq_out},
          {30'h0, od ? !act : 1'b0, od ? 1'b0 : (act ? pol : !pol)});
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   // ==========================================
   // Test sequence
   initial
   begin
      do_reset(1'b1);
      chk({31'h0, upper_pulldown_en}, 32'h0);
      access(1'b1, 1'b1, 1'b0, 7'h50, 32'h11223344);
      access(1'b0, 1'b1, 1'b0, 7'h50, 32'h0);
      chk(data_out, 32'h00000000);
      access(1'b1, 1'b1, 1'b0, 7'h50, 32'h11223344);
      access(1'b1, 1'b1, 1'b0, 7'h54, 32'h55667788);
      access(1'b1, 1'b0, 1'b0, 7'h50, 32'hDEAD0000);
      access(1'b0, 1'b1, 1'b0, 7'h50, 32'h0);
      chk(data_out, 32'h11223344);
      access(1'b0, 1'b1, 1'b0, 7'h54, 32'h0);
      chk(data_out, 32'h55667788);
      big_endian <= 1'b1;
      access(1'b0, 1'b1, 1'b0, 7'h50, 32'h0);
      chk(data_out, 32'h44332211);
      big_endian <= 1'b0;
      tx_stall <= 1'b1;
      for (int i = 0; i < 9; i++)
         access(1'b1, 1'b1, 1'b1, 7'(i * 8 + 4), 32'hA0 + i);
      tx_stall <= 1'b0;
      wait_cyc(20);
      chk(32'(i_shp_core_model.tx_count), 32'd8);
      for (int i = 0; i < 8; i++)
         chk(i_shp_core_model.tx_log[i], 32'hA0 + i);
      access(1'b0, 1'b1, 1'b1, 7'h7C, 32'h0);
      chk(data_out, 32'hC0DE0000);
      access(1'b0, 1'b1, 1'b1, 7'h04, 32'h0);
      chk(data_out, 32'hC0DE0001);
      low_power <= 1'b1;
      woke = 1'b0;
      access(1'b1, 1'b1, 1'b0, 7'h60, 32'h1);
      chk({31'h0, woke}, 32'h1);
      low_power <= 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         irq_case(k[0], k[1], 8'h01);
         irq_case(k[0], k[1], 8'h02);
      end
      irq_case(1'b1, 1'b0, 8'h01);
      irq_sources <= 8'h00;
      wait_cyc(3);
      irq_sources <= 8'h01;
      wait_cyc(6);
      chk({31'h0, irq_out}, 32'h0);
      wait_cyc(40);
      chk({31'h0, irq_out}, 32'h1);
      do_reset(1'b0);
      chk({31'h0, upper_pulldown_en}, 32'h1);
      access(1'b0, 1'b1, 1'b0, 7'h50, 32'h0);
      access(1'b1, 1'b1, 1'b0, 7'h50, 32'h1234);
      access(1'b1, 1'b1, 1'b0, 7'h51, 32'hABCD);
      access(1'b0, 1'b1, 1'b0, 7'h50, 32'h0);
      chk(data_out, 32'h00001234);
      access(1'b0, 1'b1, 1'b0, 7'h51, 32'h0);
      chk(data_out, 32'h0000ABCD);
      tally_and_finish();
   end
endmodule
